// ==== pkg/flash_ctl_regs.svh ====
// offsets, field positions, reset values and timing of the pin and status control
// assumes a 10 MHz control clock
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH
// ==========================================
// command codes
`define CMD_PD_EXIT 8'hab
`define CMD_PD_ENTER 8'hb9
`define CMD_ASI 8'h25
`define CMD_PAGE_PROG 8'h02
`define CMD_RMW 8'h0a
`define CMD_BATT 8'hef
`define CMD_TERM 8'hf0
`define CMD_SR_WRITE 8'h71
`define SR_IDX_SIX 8'h06
// ==========================================
// status register six fields
`define SIX_RESULT_HI 7
`define SIX_RESULT_LO 6
`define SIX_CFG_HI 5
`define SIX_DUR_BIT 0
`define SIX_RESET 8'h00
`define RESULT_IDLE 2'h0
`define RESULT_RUN 2'h1
`define RESULT_HIGH 2'h2
`define RESULT_LOW 2'h3
// ==========================================
// frame lengths in bytes
`define ID_BYTES 8'h05
`define PROG_MIN_BYTES 8'h05
`define SR_WR_BYTES 8'h03
// ==========================================
// timing
`define MCLK_MHZ 10
`define BATT_SHORT_US 100
`define BATT_LONG_US 1000
`endif

// ==== pkg/flash_ctl_pkg.sv ====
// types shared by the pin and status control
// assumes nothing of its surroundings
package flash_ctl_pkg;
    // bytes and counts of one finished frame
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] arg;
        logic [7:0] dat;
        logic [7:0] nbytes;
        logic [2:0] nbits;
    } frame_s;
    typedef enum logic {BATT_IDLE, BATT_RUN} batt_state_e;
endpackage : flash_ctl_pkg

// ==== rtl/flash_pin_status.sv ====
// chip select qualification, power-down exit, status interrupt, battery test,
// array error flags and shared hold/reset pin of a serial flash
// assumes an spi host in mode 0/3 on i_sck and an array engine on i_mclk
//
// Contract
// - act only when chip select rises on a whole byte of clocks
// - power-down exit runs after 8 clocks, ignored after 9 or 10
// - id fetch is 40 clocks: command, 24 dummies, 8 id bits
// - rise on 41st or 42nd clock still gives id, stays powered down
// - ready busy flag is high while program or erase runs
// - page program end sets busy and starts the array transfer
// - status interrupt command drives busy onto serial output
// - threshold field bits 5:3 picks level; low only below it
// - load field bits 2:1 picks battery test load
// - bit 0 picks load time, 100 us or 1 ms
// - battery command sets result 01 while the test runs
// - result 10 above threshold, 11 below, at completion
// - status interrupt also shows end of battery test
// - terminate clears result; hardware may clear it too
// - read-modify-write reprograms bytes of one page in one operation
// - erase or program failure sets status four bits 5:4
// - status three bit 7 picks hold or reset role of shared pin
// - quad enable disables hold and reset on shared pin
// - reset role: no commands accepted while pin is low; link side still answers status interrupt and id fetch on o_so
// - hold takes and leaves effect at next falling clock edge
// - during hold, output floats, input and clock ignored
`timescale 1ns/1ps
`include "flash_ctl_regs.svh"

module flash_pin_status
    import flash_ctl_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h5a, // arbitrary value
    parameter int BATT_SHORT_CYCLES = `BATT_SHORT_US * `MCLK_MHZ,
    parameter int BATT_LONG_CYCLES = `BATT_LONG_US * `MCLK_MHZ
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_hold_rst_n,
    input wire logic i_hold_reset_sel,
    input wire logic i_quad_lane_enable,
    input wire logic i_batt_below,
    input wire logic i_batt_result_clear,
    input wire logic i_array_done,
    input wire logic i_array_erase_err,
    input wire logic i_array_prog_err,
    output logic o_so,
    output logic o_so_oe,
    output logic o_ready_busy,
    output logic o_power_down,
    output logic o_device_reset,
    output logic o_array_start,
    output logic o_array_rmw,
    output logic o_erase_failure_flag,
    output logic o_program_failure_flag,
    output logic [7:0] o_status_six,
    output logic o_batt_load_on
);
    localparam int TW = $clog2(BATT_LONG_CYCLES + 1);

    // ==========================================
    // link side: shift on rising sck, drive on falling sck
    logic [1:0] hold_en_sync;
    logic hold_q;
    logic [6:0] sh_reg;
    logic [2:0] bit_reg;
    logic [7:0] nbytes_reg;
    logic [7:0] cmd_reg;
    logic [7:0] arg_reg;
    logic [7:0] dat_reg;
    logic asi_reg;
    logic so_reg;
    logic oe_reg;
    frame_s snap_reg;
    logic [7:0] byte_next;
    logic id_win;
    logic hold_next;
    logic ready_busy_reg;
    logic frame_tgl_reg;

    assign byte_next = {sh_reg, i_si};
    assign id_win = (cmd_reg == `CMD_PD_EXIT) && (nbytes_reg == 8'h04);
    assign hold_next = hold_en_sync[1] & ~i_hold_rst_n;

    // hold enable is a slow config level
    always_ff @(negedge i_sck or negedge i_rstn) begin
        if (!i_rstn) begin
            hold_en_sync <= 2'h0;
        end else begin
            hold_en_sync <= {hold_en_sync[0], ~i_hold_reset_sel & ~i_quad_lane_enable};
        end
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            hold_q <= 1'b0;
            so_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            hold_q <= hold_next;
            so_reg <= DEVICE_ID[3'h7 - bit_reg];
            oe_reg <= ~hold_next & (id_win | asi_reg);
        end
    end

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            sh_reg <= 7'h00;
            bit_reg <= 3'h0;
            nbytes_reg <= 8'h00;
            cmd_reg <= 8'h00;
            arg_reg <= 8'h00;
            dat_reg <= 8'h00;
            asi_reg <= 1'b0;
        end else if (!hold_q) begin
            sh_reg <= byte_next[6:0];
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                if (nbytes_reg != 8'hff) begin
                    nbytes_reg <= nbytes_reg + 8'h01;
                end
                if (nbytes_reg == 8'h00) begin
                    cmd_reg <= byte_next;
                    asi_reg <= (byte_next == `CMD_ASI);
                end
                if (nbytes_reg == 8'h01) begin
                    arg_reg <= byte_next;
                end
                if (nbytes_reg == 8'h02) begin
                    dat_reg <= byte_next;
                end
            end
        end
    end

    // frame is frozen at the chip select edge; the control side reads it
    // only after the three-stage synchroniser has seen the same edge
    // a short frame can fall between two control clocks, so the chip select
    // edge travels as a toggle rather than as a sampled level
    always_ff @(posedge i_cs_n or negedge i_rstn) begin
        if (!i_rstn) begin
            snap_reg <= '0;
            frame_tgl_reg <= 1'b1;
        end else begin
            snap_reg <= '{cmd: cmd_reg, arg: arg_reg, dat: dat_reg, nbytes: nbytes_reg, nbits: bit_reg};
            frame_tgl_reg <= ~frame_tgl_reg;
        end
    end

    // status interrupt follows busy with no clock from the host
    assign o_so = asi_reg ? ready_busy_reg : so_reg;
    assign o_so_oe = oe_reg;

    // ==========================================
    // pin synchronisers
    logic [2:0] pin_in;
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic [2:0] s3_reg;
    logic [2:0] pin_reg;

    assign pin_in = {frame_tgl_reg, i_hold_rst_n, i_batt_below};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge i_mclk or negedge i_rstn) begin
            if (!i_rstn) begin
                s1_reg[g] <= 1'b1;
                s2_reg[g] <= 1'b1;
                s3_reg[g] <= 1'b1;
                pin_reg[g] <= 1'b1;
            end else begin
                s1_reg[g] <= pin_in[g];
                s2_reg[g] <= s1_reg[g];
                s3_reg[g] <= s2_reg[g];
                if (s2_reg[g] == s3_reg[g]) begin
                    pin_reg[g] <= s3_reg[g];
                end
            end
        end
    end

    // ==========================================
    // frame qualification
    logic cs_prev_reg;
    logic cs_rise;
    logic in_reset;
    logic valid;
    logic is_pd_exit;
    logic start_op;
    logic start_batt;
    logic term;

    assign cs_rise = pin_reg[2] ^ cs_prev_reg;
    assign in_reset = i_hold_reset_sel & ~i_quad_lane_enable & ~pin_reg[1];
    assign valid = cs_rise & ~in_reset & (snap_reg.nbits == 3'h0) & (snap_reg.nbytes != 8'h00);
    // exit needs the bare command or the full id fetch
    assign is_pd_exit = valid & (snap_reg.cmd == `CMD_PD_EXIT)
        & ((snap_reg.nbytes == 8'h01) | (snap_reg.nbytes >= `ID_BYTES));
    assign start_op = valid & ~o_power_down & ~ready_busy_reg & (snap_reg.nbytes >= `PROG_MIN_BYTES)
        & ((snap_reg.cmd == `CMD_PAGE_PROG) | (snap_reg.cmd == `CMD_RMW));
    assign start_batt = valid & ~o_power_down & ~ready_busy_reg & (snap_reg.cmd == `CMD_BATT);
    assign term = valid & (snap_reg.cmd == `CMD_TERM);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_prev_reg <= 1'b1;
            o_device_reset <= 1'b0;
        end else begin
            cs_prev_reg <= pin_reg[2];
            o_device_reset <= in_reset;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_power_down <= 1'b0;
        end else if (is_pd_exit) begin
            o_power_down <= 1'b0;
        end else if (valid & (snap_reg.cmd == `CMD_PD_ENTER) & (snap_reg.nbytes == 8'h01) & ~ready_busy_reg) begin
            o_power_down <= 1'b1;
        end
    end

    // ==========================================
    // array operation and its flags
    logic array_busy_reg;
    batt_state_e batt_reg;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            array_busy_reg <= 1'b0;
            o_array_start <= 1'b0;
            o_array_rmw <= 1'b0;
        end else begin
            o_array_start <= start_op;
            if (start_op) begin
                array_busy_reg <= 1'b1;
                o_array_rmw <= (snap_reg.cmd == `CMD_RMW);
            end else if (i_array_done) begin
                array_busy_reg <= 1'b0;
            end
        end
    end

    // a failure reported with a new start still stands
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_erase_failure_flag <= 1'b0;
            o_program_failure_flag <= 1'b0;
        end else begin
            o_erase_failure_flag <= i_array_erase_err | (o_erase_failure_flag & ~start_op);
            o_program_failure_flag <= i_array_prog_err | (o_program_failure_flag & ~start_op);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ready_busy_reg <= 1'b0;
        end else begin
            ready_busy_reg <= array_busy_reg | (batt_reg == BATT_RUN);
        end
    end
    assign o_ready_busy = ready_busy_reg;

    // ==========================================
    // battery test
    logic [TW-1:0] timer_reg;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            batt_reg <= BATT_IDLE;
            timer_reg <= '0;
            o_batt_load_on <= 1'b0;
            o_status_six <= `SIX_RESET;
        end else begin
            unique case (batt_reg)
                BATT_IDLE: begin
                    if (start_batt) begin
                        batt_reg <= BATT_RUN;
                        o_batt_load_on <= 1'b1;
                        o_status_six[`SIX_RESULT_HI:`SIX_RESULT_LO] <= `RESULT_RUN;
                        timer_reg <= o_status_six[`SIX_DUR_BIT] ? TW'(BATT_LONG_CYCLES)
                            : TW'(BATT_SHORT_CYCLES);
                    end else if (term | i_batt_result_clear) begin
                        o_status_six[`SIX_RESULT_HI:`SIX_RESULT_LO] <= `RESULT_IDLE;
                    end else if (valid & (snap_reg.cmd == `CMD_SR_WRITE) & (snap_reg.arg == `SR_IDX_SIX)
                        & (snap_reg.nbytes == `SR_WR_BYTES)) begin
                        o_status_six[`SIX_CFG_HI:0] <= snap_reg.dat[`SIX_CFG_HI:0];
                    end
                end
                BATT_RUN: begin
                    if (term) begin
                        batt_reg <= BATT_IDLE;
                        o_batt_load_on <= 1'b0;
                        o_status_six[`SIX_RESULT_HI:`SIX_RESULT_LO] <= `RESULT_IDLE;
                    end else if (timer_reg == TW'(1)) begin
                        batt_reg <= BATT_IDLE;
                        o_batt_load_on <= 1'b0;
                        o_status_six[`SIX_RESULT_HI:`SIX_RESULT_LO] <= pin_reg[0] ? `RESULT_LOW
                            : `RESULT_HIGH;
                    end else begin
                        timer_reg <= timer_reg - TW'(1);
                    end
                end
            endcase
        end
    end

    // ==========================================
    // checks
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    property p_partial;
        cs_rise && snap_reg.nbits != 3'h0 |=> !o_array_start && $stable(o_power_down);
    endproperty
    a_partial: assert property (p_partial) else $error("partial frame acted on");

    property p_pd_exit;
        valid && snap_reg.cmd == `CMD_PD_EXIT && snap_reg.nbytes == 8'h01 |=> !o_power_down;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down not exited");

    property p_id_late;
        cs_rise && o_power_down && snap_reg.cmd == `CMD_PD_EXIT && snap_reg.nbytes == `ID_BYTES
            && snap_reg.nbits != 3'h0 |=> o_power_down;
    endproperty
    a_id_late: assert property (p_id_late) else $error("late id rise left power-down");

    property p_prog_busy;
        start_op |=> array_busy_reg ##1 o_ready_busy;
    endproperty
    a_prog_busy: assert property (p_prog_busy) else $error("busy not set after program");

    property p_batt_run;
        batt_reg == BATT_RUN |-> o_status_six[7:6] == `RESULT_RUN && o_batt_load_on;
    endproperty
    a_batt_run: assert property (p_batt_run) else $error("result not 01 during test");

    property p_batt_end;
        batt_reg == BATT_RUN && !term && timer_reg == TW'(1)
            |=> o_status_six[7:6] == ($past(pin_reg[0]) ? `RESULT_LOW : `RESULT_HIGH);
    endproperty
    a_batt_end: assert property (p_batt_end) else $error("wrong battery result");

    property p_term;
        term && !start_batt |=> o_status_six[7:6] == `RESULT_IDLE;
    endproperty
    a_term: assert property (p_term) else $error("terminate left result");

    property p_reset_role;
        in_reset && cs_rise |=> !o_array_start && $stable(o_status_six) && $stable(o_power_down);
    endproperty
    a_reset_role: assert property (p_reset_role) else $error("command taken in reset");

    property p_dur;
        start_batt |=> timer_reg == ($past(o_status_six[0]) ? TW'(BATT_LONG_CYCLES) : TW'(BATT_SHORT_CYCLES));
    endproperty
    a_dur: assert property (p_dur) else $error("wrong load duration");

    property p_erase_set;
        i_array_erase_err |=> o_erase_failure_flag;
    endproperty
    a_erase_set: assert property (p_erase_set) else $error("erase failure not flagged");

    property p_prog_set;
        i_array_prog_err |=> o_program_failure_flag;
    endproperty
    a_prog_set: assert property (p_prog_set) else $error("program failure not flagged");

    property p_quad;
        i_quad_lane_enable |=> !o_device_reset;
    endproperty
    a_quad: assert property (p_quad) else $error("shared pin reset while quad lanes on");

endmodule : flash_pin_status

// ==== verif/spi_host_model.sv ====
// spi host model in mode 0 that frames, clocks and shifts bytes into the flash control
// assumes the bench calls its tasks and leaves at least 1 us between frames
`timescale 1ns/1ps

module spi_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    // ==========================================
    // frame state
    logic [63:0] rx;

    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        rx = '0;
    end

    // ==========================================
    // framing, link clock only runs inside a frame
    task automatic pulse;
        #3 o_sck = 1'b1;
        rx = {rx[62:0], i_so};
        #3 o_sck = 1'b0;
    endtask : pulse

    task automatic end_frame;
        #3 o_cs_n = 1'b1;
        // a released line must not look like held data
        o_si = ~o_si;
    endtask : end_frame

    // msb first; the caller picks the count, so ragged frames are possible
    task automatic xfer(input logic [47:0] d, input int n, input bit keep);
        rx = '0;
        o_cs_n = 1'b0;
        #3;
        for (int i = 0; i < n; i++) begin
            o_si = d[n-1-i];
            pulse();
        end
        if (!keep) begin
            end_frame();
        end
    endtask : xfer
endmodule : spi_host_model

// ==== verif/test_serial_flash_pin_and_status_control.sv ====
// self-checking bench of the pin and status control
// assumes the host model drives the link; the bench drives pins and array events
`timescale 1ns/1ps
`include "flash_ctl_regs.svh"

module test_serial_flash_pin_and_status_control
    import flash_ctl_pkg::*;
;
    localparam logic [7:0] ID = 8'h5a; // arbitrary value
    logic i_mclk, i_rstn, i_sck, i_cs_n, i_si, i_hold_rst_n, i_hold_reset_sel, i_quad_lane_enable;
    logic i_batt_below, i_batt_result_clear, i_array_done, i_array_erase_err, i_array_prog_err;
    logic o_so, o_so_oe, o_ready_busy, o_power_down, o_device_reset, o_array_start, o_array_rmw;
    logic o_erase_failure_flag, o_program_failure_flag, o_batt_load_on;
    logic [7:0] o_status_six;
    int n_fail = 0;
    int n_tests = 0;
    int n_start = 0;

    // ==========================================
    // design and host
    flash_pin_status #(.DEVICE_ID(ID), .BATT_SHORT_CYCLES(40), .BATT_LONG_CYCLES(120)) u_dut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
        .i_hold_rst_n(i_hold_rst_n), .i_hold_reset_sel(i_hold_reset_sel),
        .i_quad_lane_enable(i_quad_lane_enable), .i_batt_below(i_batt_below),
        .i_batt_result_clear(i_batt_result_clear), .i_array_done(i_array_done),
        .i_array_erase_err(i_array_erase_err), .i_array_prog_err(i_array_prog_err),
        .o_so(o_so), .o_so_oe(o_so_oe), .o_ready_busy(o_ready_busy), .o_power_down(o_power_down),
        .o_device_reset(o_device_reset), .o_array_start(o_array_start), .o_array_rmw(o_array_rmw),
        .o_erase_failure_flag(o_erase_failure_flag), .o_program_failure_flag(o_program_failure_flag),
        .o_status_six(o_status_six), .o_batt_load_on(o_batt_load_on));
    spi_host_model u_host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so));

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // a start pulse lasts one cycle, so count them rather than poll
    always @(posedge i_mclk) if (o_array_start === 1'b1) n_start <= n_start + 1;

    // ==========================================
    // helpers
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_byte(name, {7'h00, exp}, {7'h00, got});
    endtask : chk_bit

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick

    // frame acts 4-5 cycles after chip select rises, busy a cycle later; 12 also keeps the 1 us spacing
    task automatic send(input logic [47:0] d, input int n);
        tick(1);
        u_host.xfer(d, n, 1'b0);
        tick(12);
    endtask : send

    task automatic wait_batt(output int n);
        n = 0;
        while (o_status_six[7:6] === 2'b01 && n < 300) begin
            tick(1);
            n++;
        end
        if (n >= 300) begin
            n_fail++;
            $display("ERROR battery test end expected done seen running");
            stop_test();
        end
    endtask : wait_batt

    // ==========================================
    // scenarios
    task automatic t_pd;
        send(`CMD_PD_ENTER, 8);
        chk_bit("enter", 1'b1, o_power_down);
        send({`CMD_PD_EXIT, 1'b0}, 9);
        chk_bit("exit 9", 1'b1, o_power_down);
        send({`CMD_PD_EXIT, 2'b00}, 10);
        chk_bit("exit 10", 1'b1, o_power_down);
        send(`CMD_PD_EXIT, 8);
        chk_bit("exit 8", 1'b0, o_power_down);
        $display("power-down exit done");
    endtask : t_pd

    task automatic t_id;
        send(`CMD_PD_ENTER, 8);
        send({`CMD_PD_EXIT, 33'h0}, 41);
        chk_byte("id 41", ID, u_host.rx[8:1]);
        chk_bit("pd 41", 1'b1, o_power_down);
        send({`CMD_PD_EXIT, 32'h0}, 40);
        chk_byte("id 40", ID, u_host.rx[7:0]);
        chk_bit("pd 40", 1'b0, o_power_down);
        $display("id fetch done");
    endtask : t_id

    task automatic t_prog;
        send({`CMD_PAGE_PROG, 32'h0}, 40);
        chk_byte("starts", 8'h01, 8'(n_start));
        chk_bit("busy", 1'b1, o_ready_busy);
        chk_bit("prog type", 1'b0, o_array_rmw);
        u_host.xfer(`CMD_ASI, 8, 1'b1);
        #20 chk_bit("asi oe", 1'b1, o_so_oe);
        chk_bit("asi so", 1'b1, o_so);
        tick(1);
        i_hold_rst_n = 1'b0;
        u_host.pulse();
        #5 chk_bit("held oe", 1'b0, o_so_oe);
        i_hold_rst_n = 1'b1;
        u_host.pulse();
        #5 chk_bit("resumed oe", 1'b1, o_so_oe);
        tick(1);
        i_array_erase_err = 1'b1;
        tick(1);
        i_array_erase_err = 1'b0;
        i_array_done = 1'b1;
        tick(1);
        i_array_done = 1'b0;
        tick(2);
        chk_bit("asi so done", 1'b0, o_so);
        chk_bit("idle", 1'b0, o_ready_busy);
        chk_bit("erase flag", 1'b1, o_erase_failure_flag);
        u_host.end_frame();
        tick(12);
        send({`CMD_RMW, 32'h0}, 40);
        chk_byte("rmw starts", 8'h02, 8'(n_start));
        chk_bit("rmw type", 1'b1, o_array_rmw);
        chk_bit("erase flag cleared", 1'b0, o_erase_failure_flag);
        i_array_prog_err = 1'b1;
        tick(1);
        i_array_prog_err = 1'b0;
        i_array_done = 1'b1;
        tick(1);
        i_array_done = 1'b0;
        tick(2);
        chk_bit("prog flag", 1'b1, o_program_failure_flag);
        $display("program and status interrupt done");
    endtask : t_prog

    task automatic t_batt;
        int n;
        i_batt_below = 1'b1;
        send({`CMD_SR_WRITE, `SR_IDX_SIX, 8'h2b}, 24);
        chk_byte("status six fields", 8'h2b, {2'b00, o_status_six[5:0]});
        send(`CMD_BATT, 8);
        chk_byte("running", 8'h01, {6'h00, o_status_six[7:6]});
        chk_bit("load", 1'b1, o_batt_load_on);
        u_host.xfer(`CMD_ASI, 8, 1'b1);
        #20 chk_bit("asi batt", 1'b1, o_so);
        wait_batt(n);
        chk_bit("long time", 1'b1, 1'(n >= 90 && n <= 115));
        chk_byte("below", 8'h03, {6'h00, o_status_six[7:6]});
        tick(2);
        chk_bit("asi batt end", 1'b0, o_so);
        u_host.end_frame();
        tick(12);
        send(`CMD_TERM, 8);
        chk_byte("terminate", 8'h00, {6'h00, o_status_six[7:6]});
        i_batt_below = 1'b0;
        send({`CMD_SR_WRITE, `SR_IDX_SIX, 8'h2a}, 24);
        send(`CMD_BATT, 8);
        wait_batt(n);
        chk_bit("short time", 1'b1, 1'(n <= 35));
        chk_byte("above", 8'h02, {6'h00, o_status_six[7:6]});
        i_batt_result_clear = 1'b1;
        tick(1);
        i_batt_result_clear = 1'b0;
        tick(2);
        chk_byte("hw clear", 8'h00, {6'h00, o_status_six[7:6]});
        $display("battery test done");
    endtask : t_batt

    task automatic t_pins;
        i_hold_reset_sel = 1'b1;
        // the link side learns the role only from clock falls, so one frame passes first
        send(`CMD_TERM, 8);
        i_hold_rst_n = 1'b0;
        tick(6);
        chk_bit("reset role", 1'b1, o_device_reset);
        send(`CMD_PD_ENTER, 8);
        chk_bit("cmd in reset", 1'b0, o_power_down);
        i_quad_lane_enable = 1'b1;
        tick(6);
        chk_bit("quad reset", 1'b0, o_device_reset);
        send(`CMD_PD_ENTER, 8);
        chk_bit("cmd in quad", 1'b1, o_power_down);
        $display("shared pin done");
    endtask : t_pins

    // ==========================================
    // main sequence
    initial begin
        {i_rstn, i_hold_reset_sel, i_quad_lane_enable, i_batt_below, i_batt_result_clear} = 5'h00;
        {i_array_done, i_array_erase_err, i_array_prog_err} = 3'h0;
        i_hold_rst_n = 1'b1;
        tick(5);
        i_rstn = 1'b1;
        tick(5);
        t_pd();
        t_id();
        t_prog();
        t_batt();
        t_pins();
        stop_test();
    end
endmodule : test_serial_flash_pin_and_status_control
